// *** hdl/sec_params.svh ***
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// Register map (word addresses on the plain port)
`define SEC_ADDR_W          4
`define SEC_REG_CTRL        4'h0
`define SEC_REG_STAT        4'h1

// Control register fields
`define SEC_CTRL_RATIO_LSB  0
`define SEC_CTRL_RATIO_MSB  2
`define SEC_CTRL_ENABLE     4
`define SEC_CTRL_RECOVER    5
`define SEC_CTRL_ON_EXIT    6

// Reset values
`define SEC_RATIO_RST       3'h0
`define SEC_CTRL_RST        8'h00

// Ratio code with a fixed ratio of 1:4
`define SEC_RATIO_FOUR      3'h1
`define SEC_COUNT_FOUR      8'h03

// Peripheral clock divider: main clock divided by four
`define SEC_PERIPH_DIV      2'h3

`endif

// *** hdl/sec_pkg.sv ***
`include "sec_params.svh"
package sec_pkg;

    typedef struct packed {
        logic [`SEC_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } sec_bus_req_t;

    typedef struct packed {
        logic irq_entry;
        logic irq_return;
    } sec_core_ev_t;

    typedef struct packed {
        logic cpu_cycle_en;
        logic flash_cycle_en;
        logic periph_quarter_en;
    } sec_clk_en_t;

    typedef enum logic [1:0] {
        SEC_RUN_FULL = 2'b00,
        SEC_RUN_SLOW = 2'b01
    } sec_rate_t;

endpackage

// *** hdl/sec_slow_exec.sv ***
// Overview of operation
// - While enabled, CPU runs one instruction cycle in every N, N from ratio.
// - Main clock and its divide-by-four enable keep running at full rate.
// - Interrupt entry copies slow_exec_enable into slow_on_exit.
// - Recover-on-interrupt set: interrupt entry clears slow_exec_enable.
// - Recover-on-interrupt clear: interrupt entry leaves slow_exec_enable unchanged.
// - Return with slow_on_exit one sets slow_exec_enable, main runs slow.
// - Return with slow_on_exit zero clears slow_exec_enable, main runs full.
// - Software may write slow_on_exit in the routine; last value decides.
// - Ratio code 001 gives one active cycle then three idle cycles.
`timescale 1ns/1ps
`include "sec_params.svh"
module sec_slow_exec (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire sec_pkg::sec_bus_req_t bus,
    output logic [7:0]                 rdata,
    input  wire sec_pkg::sec_core_ev_t core_ev,
    output sec_pkg::sec_clk_en_t       clk_en,
    output sec_pkg::sec_rate_t         rate
);
    import sec_pkg::*;

    logic [2:0] ratio_q;
    logic       slow_exec_enable_q;
    logic       recover_on_irq_q;
    logic       slow_on_exit_q;
    logic [7:0] phase_q;
    logic [7:0] phase_d;
    logic [1:0] quarter_q;
    logic [7:0] rdata_q;
    logic       ctrl_wr;
    logic       cpu_en;
    logic       settle;
    logic [8:0] gap_q;
    logic       gap_valid_q;

    // Idle cycles after each active one for a ratio code
    function automatic logic [7:0] idle_count(input logic [2:0] code);
        logic [8:0] n;
        n = 9'h000;
        if (code == `SEC_RATIO_FOUR) begin
            idle_count = `SEC_COUNT_FOUR;
        end else begin
            n = 9'h001 << ({1'b0, code} + 4'h1);
            idle_count = 8'(n - 9'h001);
        end
    endfunction

    // Full cycle length for a ratio code, written out per code
    function automatic logic [8:0] cycle_length(input logic [2:0] code);
        case (code)
            3'h0:    cycle_length = 9'h002;
            3'h1:    cycle_length = 9'h004;
            3'h2:    cycle_length = 9'h008;
            3'h3:    cycle_length = 9'h010;
            3'h4:    cycle_length = 9'h020;
            3'h5:    cycle_length = 9'h040;
            3'h6:    cycle_length = 9'h080;
            3'h7:    cycle_length = 9'h100;
            default: cycle_length = 9'h000;
        endcase
    endfunction

    // Control register image as software reads it
    function automatic logic [7:0] ctrl_word(input logic on_exit, input logic recover,
                                             input logic enable, input logic [2:0] code);
        ctrl_word = 8'h00;
        ctrl_word[`SEC_CTRL_ON_EXIT] = on_exit;
        ctrl_word[`SEC_CTRL_RECOVER] = recover;
        ctrl_word[`SEC_CTRL_ENABLE]  = enable;
        ctrl_word[`SEC_CTRL_RATIO_MSB:`SEC_CTRL_RATIO_LSB] = code;
    endfunction

    assign ctrl_wr = bus.wr && (bus.addr == `SEC_REG_CTRL);

    // Ratio and recover-on-interrupt are plain software fields
    always_ff @(posedge clock) begin
        if (rst) begin
            ratio_q          <= `SEC_RATIO_RST;
            recover_on_irq_q <= 1'b0;
        end else if (ctrl_wr) begin
            ratio_q          <= bus.wdata[`SEC_CTRL_RATIO_MSB:`SEC_CTRL_RATIO_LSB];
            recover_on_irq_q <= bus.wdata[`SEC_CTRL_RECOVER];
        end
    end

    // Enable bit: hardware events take priority over software write
    always_ff @(posedge clock) begin
        if (rst) begin
            slow_exec_enable_q <= 1'b0;
        end else if (core_ev.irq_return) begin
            slow_exec_enable_q <= slow_on_exit_q;
        end else if (core_ev.irq_entry) begin
            if (recover_on_irq_q) begin
                slow_exec_enable_q <= 1'b0;
            end else begin
                slow_exec_enable_q <= slow_exec_enable_q;
            end
        end else if (ctrl_wr) begin
            slow_exec_enable_q <= bus.wdata[`SEC_CTRL_ENABLE];
        end
    end

    // On-exit bit: captured on entry, software writable afterwards
    always_ff @(posedge clock) begin
        if (rst) begin
            slow_on_exit_q <= 1'b0;
        end else if (core_ev.irq_entry) begin
            slow_on_exit_q <= slow_exec_enable_q;
        end else if (ctrl_wr) begin
            slow_on_exit_q <= bus.wdata[`SEC_CTRL_ON_EXIT];
        end
    end

    // Phase counter: zero is the active cycle
    always_comb begin
        phase_d = phase_q;
        if (!slow_exec_enable_q || phase_q >= idle_count(ratio_q)) begin
            phase_d = 8'h00;
        end else begin
            phase_d = phase_q + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !slow_exec_enable_q || ctrl_wr) begin
            phase_q <= 8'h00;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Free-running divide-by-four enable for peripherals
    always_ff @(posedge clock) begin
        if (rst) begin
            quarter_q <= 2'h0;
        end else begin
            quarter_q <= quarter_q + 2'h1;
        end
    end

    assign cpu_en                   = !slow_exec_enable_q || (phase_q == 8'h00);
    assign clk_en.cpu_cycle_en      = cpu_en;
    assign clk_en.flash_cycle_en    = cpu_en;
    assign clk_en.periph_quarter_en = (quarter_q == `SEC_PERIPH_DIV);
    assign rate = slow_exec_enable_q ? SEC_RUN_SLOW : SEC_RUN_FULL;

    // Read data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                `SEC_REG_CTRL: rdata_q <= ctrl_word(slow_on_exit_q, recover_on_irq_q,
                                                    slow_exec_enable_q, ratio_q);
                `SEC_REG_STAT: rdata_q <= phase_q;
                default:       rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    AST_ENTRY_COPY: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_entry && !core_ev.irq_return |=> slow_on_exit_q == $past(slow_exec_enable_q))
        else $error("on-exit bit not copied on entry");
    AST_RECOVER: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_entry && !core_ev.irq_return && recover_on_irq_q |=> !slow_exec_enable_q)
        else $error("enable not cleared on recover");
    AST_KEEP: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_entry && !core_ev.irq_return && !recover_on_irq_q
        |=> $stable(slow_exec_enable_q))
        else $error("enable changed on entry without recover");
    AST_RET_SLOW: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_return && slow_on_exit_q |=> slow_exec_enable_q)
        else $error("enable not set on return");
    AST_RET_FULL: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_return && !slow_on_exit_q |=> !slow_exec_enable_q)
        else $error("enable not cleared on return");
    AST_SW_EXIT: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr && !core_ev.irq_entry |=> slow_on_exit_q == $past(bus.wdata[`SEC_CTRL_ON_EXIT]))
        else $error("software write to on-exit lost");
    AST_FOUR: assert property (@(posedge clock) disable iff (rst)
        slow_exec_enable_q && ratio_q == `SEC_RATIO_FOUR && clk_en.cpu_cycle_en
        && !core_ev.irq_entry && !core_ev.irq_return && !ctrl_wr
        ##1 (slow_exec_enable_q && ratio_q == `SEC_RATIO_FOUR)
        |-> !clk_en.cpu_cycle_en)
        else $error("active cycle not followed by idle");
    AST_FULL_RATE: assert property (@(posedge clock) disable iff (rst)
        !slow_exec_enable_q |-> clk_en.cpu_cycle_en && clk_en.flash_cycle_en)
        else $error("cpu stalled at full rate");
    AST_PERIPH: assert property (@(posedge clock) disable iff (rst)
        clk_en.periph_quarter_en |=> !clk_en.periph_quarter_en [*3] ##1 clk_en.periph_quarter_en)
        else $error("peripheral enable not every fourth cycle");
    AST_RATIO: assert property (@(posedge clock) disable iff (rst)
        slow_exec_enable_q |-> phase_q <= idle_count(ratio_q))
        else $error("phase past ratio");

    // Active-cycle spacing monitor for the assertions below
    assign settle = slow_exec_enable_q && !ctrl_wr && !core_ev.irq_entry && !core_ev.irq_return;

    always_ff @(posedge clock) begin
        if (rst || !settle) begin
            gap_q       <= 9'h000;
            gap_valid_q <= 1'b0;
        end else if (cpu_en) begin
            gap_q       <= 9'h001;
            gap_valid_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 9'h001;
        end
    end

    AST_GAP: assert property (@(posedge clock) disable iff (rst)
        gap_valid_q && cpu_en && slow_exec_enable_q |-> gap_q == cycle_length(ratio_q))
        else $error("active cycles not one in every N");

    AST_GAP_FOUR: assert property (@(posedge clock) disable iff (rst)
        gap_valid_q && cpu_en && ratio_q == `SEC_RATIO_FOUR |-> gap_q == 9'h004)
        else $error("ratio four spacing wrong");

    AST_IDLE_PHASE: assert property (@(posedge clock) disable iff (rst)
        slow_exec_enable_q && phase_q != 8'h00 |-> !clk_en.cpu_cycle_en)
        else $error("cpu active in idle phase");

    AST_START: assert property (@(posedge clock) disable iff (rst)
        $rose(slow_exec_enable_q) |-> clk_en.cpu_cycle_en && phase_q == 8'h00)
        else $error("slow mode does not start on active cycle");

    AST_PHASE_STEP: assert property (@(posedge clock) disable iff (rst)
        settle && phase_q < idle_count(ratio_q) |=> phase_q == $past(phase_q) + 8'h01)
        else $error("phase did not advance");

    AST_PHASE_WRAP: assert property (@(posedge clock) disable iff (rst)
        settle && phase_q == idle_count(ratio_q) |=> phase_q == 8'h00 && clk_en.cpu_cycle_en)
        else $error("phase did not wrap");

    AST_FULL_PHASE: assert property (@(posedge clock) disable iff (rst)
        !slow_exec_enable_q |=> phase_q == 8'h00)
        else $error("phase not cleared at full rate");

    AST_HOLD_ENABLE: assert property (@(posedge clock) disable iff (rst)
        !ctrl_wr && !core_ev.irq_entry && !core_ev.irq_return |=> $stable(slow_exec_enable_q))
        else $error("enable changed without cause");

    AST_HOLD_EXIT: assert property (@(posedge clock) disable iff (rst)
        !ctrl_wr && !core_ev.irq_entry |=> $stable(slow_on_exit_q))
        else $error("on-exit bit changed without cause");

    AST_WR_ENABLE: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr && !core_ev.irq_entry && !core_ev.irq_return
        |=> slow_exec_enable_q == $past(bus.wdata[`SEC_CTRL_ENABLE]))
        else $error("software enable write lost");

    AST_WR_RATIO: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr |=> ratio_q == $past(bus.wdata[`SEC_CTRL_RATIO_MSB:`SEC_CTRL_RATIO_LSB]))
        else $error("ratio write lost");

    AST_WR_RECOVER: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr |=> recover_on_irq_q == $past(bus.wdata[`SEC_CTRL_RECOVER]))
        else $error("recover write lost");

    AST_FULL_ON_WRITE: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr && !bus.wdata[`SEC_CTRL_ENABLE] && !core_ev.irq_entry && !core_ev.irq_return
        |=> clk_en.cpu_cycle_en && rate == SEC_RUN_FULL)
        else $error("full rate not restored by write");

    AST_ENTRY_ANY: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_entry |=> slow_on_exit_q == $past(slow_exec_enable_q))
        else $error("on-exit bit not copied on any entry");

    AST_RECOVER_RUN: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_entry && !core_ev.irq_return && recover_on_irq_q |=> clk_en.cpu_cycle_en)
        else $error("routine not at full rate");

    AST_ENTRY_RATE: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_entry && !core_ev.irq_return && !recover_on_irq_q && slow_exec_enable_q
        |=> rate == SEC_RUN_SLOW)
        else $error("routine left slow rate");

    AST_RET_SLOW_RUN: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_return && slow_on_exit_q |=> rate == SEC_RUN_SLOW)
        else $error("main not resumed slow");

    AST_RET_FULL_RUN: assert property (@(posedge clock) disable iff (rst)
        core_ev.irq_return && !slow_on_exit_q |=> rate == SEC_RUN_FULL && clk_en.cpu_cycle_en)
        else $error("main not resumed full");

    AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (rst)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data not zero without read");

    AST_RDATA_CTRL: assert property (@(posedge clock) disable iff (rst)
        bus.rd && bus.addr == `SEC_REG_CTRL |=> rdata == ctrl_word($past(slow_on_exit_q),
            $past(recover_on_irq_q), $past(slow_exec_enable_q), $past(ratio_q)))
        else $error("control read mismatch");

    AST_RDATA_STAT: assert property (@(posedge clock) disable iff (rst)
        bus.rd && bus.addr == `SEC_REG_STAT |=> rdata == $past(phase_q))
        else $error("status read mismatch");

    AST_RDATA_NONE: assert property (@(posedge clock) disable iff (rst)
        bus.rd && bus.addr != `SEC_REG_CTRL && bus.addr != `SEC_REG_STAT
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    AST_PERIPH_SLOW: assert property (@(posedge clock) disable iff (rst)
        slow_exec_enable_q && clk_en.periph_quarter_en |=> ##3 clk_en.periph_quarter_en)
        else $error("peripheral enable slowed");

endmodule

// *** test/sec_core_model.sv ***
`timescale 1ns/1ps
module sec_core_model (
    input  wire logic                  clock,
    input  wire sec_pkg::sec_clk_en_t  clk_en,
    output sec_pkg::sec_core_ev_t      core_ev
);
    import sec_pkg::*;
    logic in_isr = 1'b0;
    initial core_ev = '0;
    // Events land only on an active instruction cycle, entry before return
    task automatic event_pulse(input logic ret);
        @(posedge clock);
        #1;
        while (clk_en.cpu_cycle_en !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        if (ret == in_isr) begin
            core_ev.irq_entry  <= !ret;
            core_ev.irq_return <= ret;
            in_isr             <= !ret;
            @(posedge clock);
            core_ev <= '0;
        end
    endtask
endmodule

// *** test/sec_slow_exec_bench.sv ***
`timescale 1ns/1ps
`include "sec_params.svh"
module sec_slow_exec_bench;
    import sec_pkg::*;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    sec_bus_req_t bus = '0;
    logic [7:0]   rdata;
    sec_core_ev_t core_ev;
    sec_clk_en_t  clk_en;
    sec_rate_t    rate;
    logic [7:0]   exp_q[$];
    logic         rd_d = 1'b0;
    logic         en, rc, en2, oe;
    logic [2:0]   ratio;
    int           errors = 0;
    int           total_checks = 0;
    int           cycles = 0;
    int           n, hits, quarters;
    always #2.5 clock = ~clock;
    sec_slow_exec sec_slow_exec_inst (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
        .core_ev(core_ev), .clk_en(clk_en), .rate(rate));
    sec_core_model sec_core_model_inst (.clock(clock), .clk_en(clk_en), .core_ev(core_ev));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        bus.rd <= 1'b0;
    endtask
    // Read data stand in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= bus.rd;
        if (rd_d) check("rdata", rdata, exp_q.pop_front());
        cycles++;
        if (cycles == 6000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'hfc11));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd(`SEC_REG_CTRL, `SEC_CTRL_RST);
        rd(`SEC_REG_STAT, 8'h00);
        rd(4'hf, 8'h00);
        for (int c = 0; c < 8; c++) begin
            n = (c == 1) ? 4 : (1 << (c + 1));
            hits = 0;
            quarters = 0;
            wr(`SEC_REG_CTRL, 8'h10 | c[7:0]);
            for (int i = 0; i < 2 * n; i++) begin
                #1;
                hits += int'(clk_en.cpu_cycle_en === 1'b1);
                quarters += int'(clk_en.periph_quarter_en === 1'b1);
                check("flash", {7'h0, clk_en.flash_cycle_en}, {7'h0, clk_en.cpu_cycle_en});
                @(posedge clock);
            end
            check("active", hits[7:0], 8'h02);
            check("quarter", quarters[7:0], n[8:1]);
            check("rate", {6'h0, rate}, {6'h0, SEC_RUN_SLOW});
            rd(`SEC_REG_STAT, 8'h01);
        end
        for (int k = 0; k < 4; k++) begin
            en = k[0];
            rc = k[1];
            oe = 1'($urandom);
            ratio = 3'($urandom);
            en2 = rc ? 1'b0 : en;
            wr(`SEC_REG_CTRL, {1'b0, !en, rc, en, 1'b0, ratio});
            sec_core_model_inst.event_pulse(1'b0);
            rd(`SEC_REG_CTRL, {1'b0, en, rc, en2, 1'b0, ratio});
            wr(`SEC_REG_CTRL, {1'b0, oe, rc, en2, 1'b0, ratio});
            sec_core_model_inst.event_pulse(1'b1);
            rd(`SEC_REG_CTRL, {1'b0, oe, rc, oe, 1'b0, ratio});
            #1;
            check("rate", {6'h0, rate}, {7'h0, oe});
        end
        repeat (3) @(posedge clock);
        summarize();
    end
endmodule
